// ==== ccl_conditioner.sv ====
// Purpose: Configuration shift register and active configuration of the conditioner.
// Assumes: Loader keeps the shift/update ordering; external feedback comes from a pad buffer.
// Notes: Variant parameter drops the upper eight bits.
`timescale 1ns/100ps
module ccl_conditioner
  import ccl_pkg::*;
#(
  parameter bit MIXED_SIGNAL = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial link.
  ccl_link_if.device link,
  // Clock inputs to the phase detector.
  input wire logic reference_clock_in_i,
  input wire logic external_feedback_i,
  input wire logic internal_feedback_i,
  // Decoded configuration.
  output logic [88:0] active_cfg_o,
  output logic [1:0] output_mux_select_o,
  output logic out_c_half_divide_o,
  output logic out_b_half_divide_o,
  output logic out_a_half_divide_o,
  output logic detector_ref_o,
  output logic detector_fb_o
);
  logic [88:0] shift_r, shift_nxt;
  logic [88:0] act_r, act_nxt;
  logic [88:0] keep_mask;

  // Bits above the base set are absent in the plain variant.
  assign keep_mask = MIXED_SIGNAL ? {CFG_FULL_BITS{1'b1}} : {8'h00, {CFG_BASE_BITS{1'b1}}};

  always_comb begin
    shift_nxt = shift_r;
    act_nxt = act_r;
    if (link.link_tick && link.config_shift_enable) begin
      if (MIXED_SIGNAL) begin
        shift_nxt = {link.config_serial_in, shift_r[88:1]};
      end else begin
        // The plain variant has no upper eight bits, so data enters at the top of the base set.
        shift_nxt = {8'h00, link.config_serial_in, shift_r[80:1]};
      end
    end
    if (link.link_tick && link.config_update_strobe && !link.config_shift_enable) begin
      act_nxt = shift_r & keep_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shift_r <= CFG_RESET;
      act_r <= CFG_RESET;
    end else begin
      shift_r <= shift_nxt;
      act_r <= act_nxt;
    end
  end

  // Don't-care bits are cleared so they cannot steer anything downstream.
  assign active_cfg_o = act_r & ~DONT_CARE_MASK;
  assign output_mux_select_o = act_r[MUX_SEL_HI:MUX_SEL_LO];
  assign out_c_half_divide_o = act_r[HALF_C_BIT];
  assign out_b_half_divide_o = act_r[HALF_B_BIT];
  assign out_a_half_divide_o = act_r[HALF_A_BIT];
  assign detector_ref_o = reference_clock_in_i;
  // Select bit sits outside both don't-care ranges so it is never masked off.
  assign detector_fb_o = act_r[EXT_FB_BIT] ? external_feedback_i : internal_feedback_i;
endmodule : ccl_conditioner

// ==== ccl_link_if.sv ====
// Purpose: Serial configuration link between loader and conditioner.
// Assumes: Both ends share clk_i.
// Notes: Signals are plain levels sampled at link enable.
`timescale 1ns/100ps
interface ccl_link_if;
  logic config_serial_in;
  logic config_shift_enable;
  logic config_update_strobe;
  logic link_tick;
  modport loader (output config_serial_in, output config_shift_enable,
    output config_update_strobe, output link_tick);
  modport device (input config_serial_in, input config_shift_enable,
    input config_update_strobe, input link_tick);
endinterface : ccl_link_if

// ==== ccl_link_props.sv ====
// Purpose: Ordering checks on the serial link.
// Assumes: One clock; link levels move only at ticks.
// Notes: Frame length is counted in helper logic.
`timescale 1ns/100ps
module ccl_link_props (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Link.
  input wire logic config_serial_in,
  input wire logic config_shift_enable,
  input wire logic config_update_strobe,
  input wire logic link_tick
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (config_update_strobe) cnt_nxt = 8'h00;
    else if (link_tick && config_shift_enable) cnt_nxt = cnt_r + 8'h01;
  end
  always_ff @(posedge clk_i) cnt_r <= reset_i ? 8'h00 : cnt_nxt;
  sequence s_quiet; !config_update_strobe [*2]; endsequence
  property p_apart; config_shift_enable |-> !config_update_strobe; endproperty
  a_apart: assert property (p_apart) else $error("update during shift");
  property p_gap; $fell(config_shift_enable) |-> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("no gap before update");
  property p_len; $rose(config_update_strobe) |-> cnt_r == 8'h51 || cnt_r == 8'h59; endproperty
  a_len: assert property (p_len) else $error("bad frame length");
  property p_drop; config_update_strobe |-> ##[1:8] !config_update_strobe; endproperty
  a_drop: assert property (p_drop) else $error("update held");
  property p_hold;
    !link_tick |=> $stable({config_serial_in, config_shift_enable, config_update_strobe});
  endproperty
  a_hold: assert property (p_hold) else $error("link moved off tick");
  sequence s_tick_gap; !link_tick [*3] ##1 link_tick; endsequence
  property p_tick; link_tick |=> s_tick_gap; endproperty
  a_tick: assert property (p_tick) else $error("link tick spacing wrong");
endmodule : ccl_link_props

// ==== ccl_loader.sv ====
// Purpose: Core-logic loader acting as a small TAP for the configuration register.
// Assumes: Avalon-MM master writes a word image then starts a load.
// Notes: Shifts LSB first, one bit per link tick, then one update tick.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module ccl_loader
  import ccl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial link.
  ccl_link_if.loader link
);
  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_SHIFT, ST_GAP, ST_UPDATE} ccl_state_e;
  ccl_state_e st_r;
  ccl_state_e st_nxt;
  logic [88:0] img_r;
  logic [88:0] img_nxt;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic full_r;
  logic full_nxt;
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic ack_r;
  logic ack_nxt;
  logic tick;
  logic take;
  logic land;
  logic [6:0] total;

  // The divider makes the one-cycle tick at which both ends of the link move.
  assign tick = (div_r == 4'(SHIFT_DIV - 1));

  always_comb begin
    div_nxt = div_r + 4'h1;
    if (tick) begin
      div_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // A request is taken while no answer is pending; the answer stands for one cycle.
  assign take = (avs_read_i || avs_write_i) && !ack_r;
  // A write lands only at the edge where the master sees waitrequest low.
  assign land = avs_write_i && ack_r;

  always_comb begin
    ack_nxt = 1'b0;
    rd_nxt = 32'h0;
    if (take) begin
      ack_nxt = 1'b1;
      unique case (avs_address_i)
        REG_CTRL: begin
          rd_nxt = full_r ? CTRL_FULL_BIT : 32'h0;
        end
        REG_STATUS: begin
          rd_nxt = {31'h0, st_r != ST_IDLE};
        end
        REG_DATA0: begin
          rd_nxt = img_r[31:0];
        end
        REG_DATA1: begin
          rd_nxt = img_r[63:32];
        end
        default: begin
          rd_nxt = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_r <= 32'h0;
      ack_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign total = full_r ? 7'(CFG_FULL_BITS) : 7'(CFG_BASE_BITS);

  always_comb begin
    st_nxt = st_r;
    img_nxt = img_r;
    cnt_nxt = cnt_r;
    full_nxt = full_r;
    // Writes are ignored while a load runs so the frame on the link stays coherent.
    if (land && st_r == ST_IDLE) begin
      unique case (avs_address_i)
        REG_CTRL: begin
          full_nxt = |(avs_writedata_i & CTRL_FULL_BIT);
          // The frame waits for the next tick, so the link never moves between ticks.
          if (|(avs_writedata_i & CTRL_START_BIT)) begin
            st_nxt = ST_ARM;
          end
        end
        REG_STATUS: ;
        REG_DATA0: begin
          img_nxt[31:0] = avs_writedata_i;
        end
        REG_DATA1: begin
          img_nxt[63:32] = avs_writedata_i;
        end
        default: begin
          img_nxt[88:64] = avs_writedata_i[24:0];
        end
      endcase
    end
    if (tick) begin
      unique case (st_r)
        ST_IDLE: ;
        ST_ARM: begin
          st_nxt = ST_SHIFT;
          cnt_nxt = 7'h0;
        end
        ST_SHIFT: begin
          img_nxt = {img_r[0], img_r[88:1]};
          cnt_nxt = cnt_r + 7'h1;
          if (cnt_r == total - 7'h1) begin
            st_nxt = ST_GAP;
          end
        end
        ST_GAP: begin
          st_nxt = ST_UPDATE;
        end
        ST_UPDATE: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      img_r <= CFG_RESET;
      cnt_r <= 7'h0;
      full_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      img_r <= img_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
    end
  end

  assign avs_readdata_o = rd_r;
  assign avs_waitrequest_o = !ack_r;
  assign link.link_tick = tick;
  // Serial data is held low outside a frame so image writes never show on the link.
  assign link.config_serial_in = (st_r == ST_SHIFT) ? img_r[0] : 1'b0;
  assign link.config_shift_enable = (st_r == ST_SHIFT);
  assign link.config_update_strobe = (st_r == ST_UPDATE);
endmodule : ccl_loader

// ==== ccl_pkg.sv ====
// Purpose: Shared constants for the clock conditioner configuration loader.
// Assumes: One 125 MHz clock; the serial link runs on one-cycle enable pulses.
// Notes: Both ends read these constants; the link checker does not import them and hard-codes its frame lengths.
// Operation
// - Loader shifts all 89 configuration bits serially; with CTRL_FULL_BIT clear the loader shifts only 81.
// - After shifting, drop shift, then raise update.
// - Update low whenever shift enable is high.
// - Update returns low until next update wanted.
// - Bits 71-73 and 77-80 change nothing.
// - Bits 88:87 select output mux inputs.
// - Bits 86,85,84 enable half divide C,B,A.
// - Bits 81-88 only in mixed-signal variant.
// - External feedback replaces internal feedback at detector.
// - External feedback comes only from dedicated input.
// - Core-logic loader supplies data, shift and update.
package ccl_pkg;
  localparam int CFG_BASE_BITS = 81;
  localparam int CFG_FULL_BITS = 89;
  localparam int MUX_SEL_HI = 88;
  localparam int MUX_SEL_LO = 87;
  localparam int HALF_C_BIT = 86;
  localparam int HALF_B_BIT = 85;
  localparam int HALF_A_BIT = 84;
  // The external-feedback select sits between the two don't-care ranges so it stays live.
  localparam int EXT_FB_BIT = 76;
  localparam logic [88:0] CFG_RESET = 89'h0;
  localparam logic [88:0] DONT_CARE_MASK = {8'h00, 4'hF, 3'h0, 3'h7, 71'h0};
  localparam int SHIFT_DIV = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA0 = 4'h8;
  localparam logic [3:0] REG_DATA1 = 4'hC;
  localparam logic [31:0] CTRL_START_BIT = 32'h0000_0001;
  localparam logic [31:0] CTRL_FULL_BIT = 32'h0000_0002;
  localparam int DATA_WORD_BITS = 32;
endpackage : ccl_pkg

// ==== clock_conditioner_config_loader_tb.sv ====
// Purpose: Bench for loader and conditioner on one link.
// Assumes: Bus answer comes after the request is taken.
// Notes: Feedback and reference inputs are driven so each detector path is seen.
`timescale 1ns/100ps
module clock_conditioner_config_loader_tb;
  import ccl_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic ref_clk = 1'b0;
  logic ext_fb = 1'b1;
  logic int_fb = 1'b0;
  localparam logic [88:0] IMG_A = 89'h15A_C3F0_9E1B_2D4C_7A86_5B;
  localparam logic [88:0] IMG_C = 89'h0A5_3C0F_61E4_D2B3_8579_A4;
  logic [31:0] rdat, q;
  logic wt, hc, hb, ha, dref, dfb;
  logic [88:0] act;
  logic [88:0] prev = 89'h0;
  logic [1:0] mux;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  ccl_link_if link();
  ccl_loader ccl_loader_inst (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .link(link));
  ccl_conditioner ccl_conditioner_inst (.clk_i(clk_i), .reset_i(reset_i), .link(link),
    .reference_clock_in_i(ref_clk), .external_feedback_i(ext_fb), .internal_feedback_i(int_fb),
    .active_cfg_o(act), .output_mux_select_o(mux), .out_c_half_divide_o(hc),
    .out_b_half_divide_o(hb), .out_a_half_divide_o(ha), .detector_ref_o(dref),
    .detector_fb_o(dfb));
  ccl_link_props ccl_link_props_inst (.clk_i(clk_i), .reset_i(reset_i),
    .config_serial_in(link.config_serial_in), .config_shift_enable(link.config_shift_enable),
    .config_update_strobe(link.config_update_strobe), .link_tick(link.link_tick));
  always #4 clk_i = ~clk_i;
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [88:0] e, input logic [88:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_i); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic load(input logic [88:0] img, input logic full, input logic [88:0] exp);
    bus(1'b1, REG_DATA0, img[31:0]);
    bus(1'b1, REG_DATA1, img[63:32]);
    bus(1'b1, 4'h1, {7'h00, img[88:64]});
    bus(1'b1, REG_CTRL, CTRL_START_BIT | (full ? CTRL_FULL_BIT : 32'h0));
    // This write lands mid-frame and must be ignored.
    bus(1'b1, REG_DATA0, ~img[31:0]);
    chk("hold", prev, act);
    do bus(1'b0, REG_STATUS, 32'h0); while (q[0] !== 1'b0);
    prev = exp & ~DONT_CARE_MASK;
    chk("cfg", prev, act);
    chk("mux", {87'h0, exp[88:87]}, {87'h0, mux});
    chk("half", {86'h0, exp[86:84]}, {86'h0, hc, hb, ha});
    ext_fb <= 1'b1;
    int_fb <= 1'b0;
    @(posedge clk_i);
    chk("fb", {88'h0, exp[EXT_FB_BIT]}, {88'h0, dfb});
    ext_fb <= 1'b0;
    int_fb <= 1'b1;
    @(posedge clk_i);
    chk("fb", {88'h0, !exp[EXT_FB_BIT]}, {88'h0, dfb});
  endtask : load
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", {57'h0, CTRL_FULL_BIT}, {57'h0, q});
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", 89'h0, {57'h0, q});
    load(IMG_A, 1'b1, IMG_A);
    load(~IMG_A, 1'b1, ~IMG_A);
    // A short frame lands at the top of the shift register, behind the last full image.
    load(IMG_C, 1'b0, {IMG_C[80:0], ~IMG_A[88:81]});
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 89'h0, {57'h0, q});
    ref_clk <= 1'b1;
    @(posedge clk_i);
    chk("ref", 89'h1, {88'h0, dref});
    ref_clk <= 1'b0;
    @(posedge clk_i);
    chk("ref", 89'h0, {88'h0, dref});
    summarize();
  end
endmodule : clock_conditioner_config_loader_tb
